// *** logic/logic_output_combiner.sv ***
`timescale 1ns/1ps
// Contract
// - Three independent units, own operands and operator
// - Operator 00 AND, 01 OR, 02 XOR
// - Truth tables as standard AND, OR, XOR
// - Operands exclude results, option output, unassigned
// - Results routable to two terminals or relay
// - Defaults: operands 00, unit3 B 01, AND
// - Selection writes refused while drive runs
module logic_output_combiner (
    // Clock and reset
    input  wire logic                 clk,
    input  wire logic                 reset,
    // Drive mode and factory restore
    input  wire logic                 runMode,
    input  wire logic                 restoreDefaults,
    // Selection write port
    input  wire logic                 cfgWrite,
    input  wire logic [1:0]           cfgUnit,
    input  wire logic [1:0]           cfgField,
    input  wire logic [5:0]           cfgValue,
    // Terminal function writes
    input  wire logic                 termWrite,
    input  wire logic [1:0]           termSel,
    input  wire logic [5:0]           termValue,
    // Discrete status flags, indexed by function code
    input  wire logic [63:0]          statusFlags,
    // Results and routed outputs
    output logic [2:0]                combinedResult,
    output logic                      firstTerminalOut,
    output logic                      secondTerminalOut,
    output logic                      relayOut,
    // Write status
    output logic                      cfgRejected
);
    // =========================================================
    // State
    // =========================================================
    typedef struct packed {
        logic_output_pkg::unit_cfg_t [2:0] cfg;   // Unit selections
        logic [5:0] firstTermFunc;                // Terminal 1 function
        logic [5:0] secondTermFunc;               // Terminal 2 function
        logic [5:0] relayFunc;                    // Relay function
        logic [2:0] result;                       // Registered results
        logic       term1;                        // Terminal 1 level
        logic       term2;                        // Terminal 2 level
        logic       relay;                        // Relay level
        logic       rejected;                     // Set by a refused write, cleared by an accepted selection write or restore
    } state_t;

    state_t     s_q;        // Registered state
    state_t     s_d;        // Next state
    logic [2:0] rawResult;  // Operator outputs

    // Operand legality check
    function automatic logic legalOperand(input logic [5:0] f);
        legalOperand = (f != logic_output_pkg::FN_RESULT1) &&
                       (f != logic_output_pkg::FN_RESULT2) &&
                       (f != logic_output_pkg::FN_RESULT3) &&
                       (f != logic_output_pkg::FN_OPTION_OUT) &&
                       (f != logic_output_pkg::FN_UNASSIGNED);
    endfunction

    // Terminal source lookup: results or plain status flags
    function automatic logic termLevel(input logic [5:0] f,
                                       input logic [2:0] r,
                                       input logic [63:0] flags);
        case (f)
            logic_output_pkg::FN_RESULT1:    termLevel = r[0];
            logic_output_pkg::FN_RESULT2:    termLevel = r[1];
            logic_output_pkg::FN_RESULT3:    termLevel = r[2];
            logic_output_pkg::FN_UNASSIGNED: termLevel = 1'b0;
            default:                         termLevel = flags[f];
        endcase
    endfunction

    // =========================================================
    // Units
    // =========================================================
    // One operator instance per unit
    generate
        for (genvar u = 0; u < logic_output_pkg::UNITS; u++) begin : g_unit
            logic_op_unit u_op (
                .opA    (statusFlags[s_q.cfg[u].opA]),
                .opB    (statusFlags[s_q.cfg[u].opB]),
                .oper   (s_q.cfg[u].oper),
                .result (rawResult[u])
            );
        end
    endgenerate

    // =========================================================
    // Next state
    // =========================================================
    always_comb begin
        s_d = s_q;
        // Results sampled every cycle
        s_d.result = rawResult;
        // Routed outputs use the registered results
        s_d.term1 = termLevel(s_q.firstTermFunc, s_q.result,
                              statusFlags);
        s_d.term2 = termLevel(s_q.secondTermFunc, s_q.result,
                              statusFlags);
        s_d.relay = termLevel(s_q.relayFunc, s_q.result,
                              statusFlags);
        if (restoreDefaults && !runMode) begin
            // Factory restore also obeys the stop-only lock
            for (int u = 0; u < 3; u++) begin
                s_d.cfg[u].opA  = logic_output_pkg::DEF_OPERAND;
                s_d.cfg[u].opB  = logic_output_pkg::DEF_OPERAND;
                s_d.cfg[u].oper = logic_output_pkg::DEF_OPERATOR;
            end
            s_d.cfg[2].opB = logic_output_pkg::DEF_U3_OPB;
            s_d.rejected = 1'b0;
        end else if (cfgWrite) begin
            // Refuse in run mode, bad unit, or illegal value
            if (runMode || cfgUnit == 2'h3) begin
                s_d.rejected = 1'b1;
            end else if (cfgField == 2'h0) begin
                s_d.rejected = !legalOperand(cfgValue);
                if (legalOperand(cfgValue)) begin
                    s_d.cfg[cfgUnit].opA = cfgValue;
                end
            end else if (cfgField == 2'h1) begin
                s_d.rejected = !legalOperand(cfgValue);
                if (legalOperand(cfgValue)) begin
                    s_d.cfg[cfgUnit].opB = cfgValue;
                end
            end else if (cfgField == 2'h2 && cfgValue <= 6'h02) begin
                s_d.cfg[cfgUnit].oper = cfgValue[1:0];
                s_d.rejected = 1'b0;
            end else begin
                s_d.rejected = 1'b1;
            end
        end
        // Terminal routing writes, also stop-only
        if (termWrite) begin
            if (runMode || termSel == 2'h3) begin
                s_d.rejected = 1'b1;
            end else if (termSel == 2'h0) begin
                s_d.firstTermFunc = termValue;
            end else if (termSel == 2'h1) begin
                s_d.secondTermFunc = termValue;
            end else begin
                s_d.relayFunc = termValue;
            end
        end
    end

    // =========================================================
    // Registers
    // =========================================================
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            s_q <= '0;
            s_q.cfg[2].opB      <= logic_output_pkg::DEF_U3_OPB;
            s_q.firstTermFunc   <= logic_output_pkg::DEF_TERM_FUNC;
            s_q.secondTermFunc  <= logic_output_pkg::DEF_TERM_FUNC;
            s_q.relayFunc       <= logic_output_pkg::DEF_TERM_FUNC;
        end else begin
            s_q <= s_d;
        end
    end

    // Outputs straight from flip-flops
    assign combinedResult    = s_q.result;
    assign firstTerminalOut  = s_q.term1;
    assign secondTerminalOut = s_q.term2;
    assign relayOut          = s_q.relay;
    assign cfgRejected       = s_q.rejected;

    // =========================================================
    // Checks
    // =========================================================
    // Selections frozen while the drive runs, restore included
    a_run_lock: assert property (@(posedge clk) disable iff (reset)
        runMode |=> s_q.cfg == $past(s_q.cfg))
        else $error("Selection changed in run mode");
    // Results lag their operands by exactly one clock
    a_result_follow: assert property (
        @(posedge clk) disable iff (reset)
        ##1 combinedResult == $past(rawResult))
        else $error("Result did not follow operands");
    // No unit may ever hold a refused operand code
    a_legal_ops: assert property (
        @(posedge clk) disable iff (reset)
        legalOperand(s_q.cfg[0].opA) && legalOperand(s_q.cfg[0].opB) &&
        legalOperand(s_q.cfg[1].opA) && legalOperand(s_q.cfg[1].opB) &&
        legalOperand(s_q.cfg[2].opA) && legalOperand(s_q.cfg[2].opB))
        else $error("Illegal operand stored");
    // Operator code 3 is never stored in any unit
    a_oper_range: assert property (
        @(posedge clk) disable iff (reset)
        s_q.cfg[0].oper != 2'h3 && s_q.cfg[1].oper != 2'h3 &&
        s_q.cfg[2].oper != 2'h3)
        else $error("Illegal operator stored");
    // A stopped restore lands the defaults for unit one operand A and operator and unit three operand B
    a_restore_val: assert property (
        @(posedge clk) disable iff (reset)
        restoreDefaults && !runMode |=>
        s_q.cfg[2].opB == logic_output_pkg::DEF_U3_OPB &&
        s_q.cfg[0].opA == logic_output_pkg::DEF_OPERAND &&
        s_q.cfg[0].oper == logic_output_pkg::DEF_OPERATOR)
        else $error("Defaults not loaded");
    // Operator truth tables, one unit each
    a_and_table: assert property (
        @(posedge clk) disable iff (reset)
        s_q.cfg[0].oper == 2'h0 |-> rawResult[0] ==
        (statusFlags[s_q.cfg[0].opA] & statusFlags[s_q.cfg[0].opB]))
        else $error("AND result wrong");
    a_or_table: assert property (
        @(posedge clk) disable iff (reset)
        s_q.cfg[2].oper == 2'h1 |-> rawResult[2] ==
        (statusFlags[s_q.cfg[2].opA] | statusFlags[s_q.cfg[2].opB]))
        else $error("OR result wrong");
    a_xor_table: assert property (
        @(posedge clk) disable iff (reset)
        s_q.cfg[1].oper == 2'h2 |-> rawResult[1] ==
        (statusFlags[s_q.cfg[1].opA] ^ statusFlags[s_q.cfg[1].opB]))
        else $error("XOR result wrong");
    // Relay routed to unit three shows its result a clock later
    a_relay_route: assert property (
        @(posedge clk) disable iff (reset)
        s_q.relayFunc == 6'h23 && $stable(s_q.relayFunc)
        |=> relayOut == $past(combinedResult[2]))
        else $error("Relay route wrong");
    // Writes in run mode are flagged as refused
    a_reject_run: assert property (
        @(posedge clk) disable iff (reset)
        cfgWrite && runMode && !termWrite |=> cfgRejected)
        else $error("Run write not flagged");
    // Refused operand codes are flagged
    a_bad_operand: assert property (
        @(posedge clk) disable iff (reset)
        cfgWrite && !restoreDefaults && !termWrite && cfgField < 2'h2 &&
        !legalOperand(cfgValue) |=> cfgRejected)
        else $error("Bad operand not flagged");
    // A write to unit one leaves the other units alone
    a_unit_keep: assert property (
        @(posedge clk) disable iff (reset)
        cfgWrite && !restoreDefaults && cfgUnit == 2'h0
        |=> s_q.cfg[2:1] == $past(s_q.cfg[2:1]))
        else $error("Unit write disturbed another unit");
endmodule

// *** logic/logic_output_pkg.sv ***
package logic_output_pkg;
    // =========================================================
    // Sizes
    // =========================================================
    localparam int UNITS     = 3;    // Independent combiner units
    localparam int FUNC_W    = 6;    // Width of a function code
    localparam int NUM_FUNCS = 64;   // Status flags offered to selectors
    localparam int OPER_W    = 2;    // Width of an operator code

    // =========================================================
    // Operator codes
    // =========================================================
    localparam logic [1:0] OP_AND = 2'h0;
    localparam logic [1:0] OP_OR  = 2'h1;
    localparam logic [1:0] OP_XOR = 2'h2;

    // =========================================================
    // Function codes that an operand may not use
    // =========================================================
    localparam logic [5:0] FN_RESULT1    = 6'h21; // Combined result 1
    localparam logic [5:0] FN_RESULT2    = 6'h22; // Combined result 2
    localparam logic [5:0] FN_RESULT3    = 6'h23; // Combined result 3
    localparam logic [5:0] FN_OPTION_OUT = 6'h2C; // Option card output
    localparam logic [5:0] FN_UNASSIGNED = 6'h3F; // Unassigned

    // =========================================================
    // Factory defaults
    // =========================================================
    localparam logic [5:0] DEF_OPERAND   = 6'h00;
    localparam logic [5:0] DEF_U3_OPB    = 6'h01;
    localparam logic [1:0] DEF_OPERATOR  = 2'h0;
    localparam logic [5:0] DEF_TERM_FUNC = 6'h3F;

    // State of one unit's selections
    typedef struct packed {
        logic [5:0] opA;
        logic [5:0] opB;
        logic [1:0] oper;
    } unit_cfg_t;
endpackage

// *** logic/logic_op_unit.sv ***
`timescale 1ns/1ps
// Combinational two-operand operator
module logic_op_unit (
    // Operands and operator
    input  wire logic       opA,
    input  wire logic       opB,
    input  wire logic [1:0] oper,
    // Result
    output logic            result
);
    // =========================================================
    // Operator decode
    // =========================================================
    // Unused code 3 yields 0 so a bad code cannot assert outputs
    always_comb begin
        case (oper)
            logic_output_pkg::OP_AND: result = opA & opB;
            logic_output_pkg::OP_OR:  result = opA | opB;
            logic_output_pkg::OP_XOR: result = opA ^ opB;
            default:                  result = 1'b0;
        endcase
    end
endmodule

// *** tb/flag_source.sv ***
`timescale 1ns/1ps
// =========================================
// Status flag source standing for the core
// =========================================
module flag_source (
    // Clock and update request
    input  wire logic        clk,
    input  wire logic        update,
    input  wire logic [63:0] nextFlags,
    // Flags as the drive core presents them
    output logic      [63:0] statusFlags
);
    // Start from a known level
    initial statusFlags = 64'h0;
    // Move on the falling edge only, so the combiner samples settled levels
    always @(negedge clk) begin
        if (update) begin
            statusFlags <= nextFlags;
        end
    end
endmodule

// *** tb/test_programmable_logic_output_combiner.sv ***
`timescale 1ns/1ps
module test_programmable_logic_output_combiner;
    // =========================================
    // Stimulus and observed signals
    // =========================================
    logic        clk = 0, reset = 1, runMode = 0, restoreDefaults = 0;
    logic        cfgWrite = 0, termWrite = 0, flagUpdate = 0;
    logic [1:0]  cfgUnit = 2'h0, cfgField = 2'h0, termSel = 2'h0;
    logic [5:0]  cfgValue = 6'h00, termValue = 6'h00;
    logic [63:0] nextFlags = 64'h0, statusFlags;
    logic [2:0]  combinedResult, mRes, mTerm;
    logic        firstTerminalOut, secondTerminalOut, relayOut, cfgRejected;
    logic        mRej;
    logic [2:0]  routed;
    assign routed = {relayOut, secondTerminalOut, firstTerminalOut};
    int          mA[3], mB[3], mOp[3], mT[3];
    int          n_fail = 0, num_checks = 0;
    logic [31:0] rng = 32'h00008F61;
    always #10 clk = ~clk;
    flag_source i_src (.clk(clk), .update(flagUpdate),
        .nextFlags(nextFlags), .statusFlags(statusFlags));
    logic_output_combiner i_dut (.clk(clk), .reset(reset),
        .runMode(runMode), .restoreDefaults(restoreDefaults),
        .cfgWrite(cfgWrite), .cfgUnit(cfgUnit), .cfgField(cfgField),
        .cfgValue(cfgValue), .termWrite(termWrite), .termSel(termSel),
        .termValue(termValue), .statusFlags(statusFlags),
        .combinedResult(combinedResult),
        .firstTerminalOut(firstTerminalOut),
        .secondTerminalOut(secondTerminalOut), .relayOut(relayOut),
        .cfgRejected(cfgRejected));
    // =========================================
    // Reference model, one step per rising edge
    // =========================================
    always @(posedge clk or posedge reset) begin
        logic [2:0] nr, nt;
        logic       ok;
        if (reset) begin
            mA = '{0, 0, 0}; mB = '{0, 0, 1}; mOp = '{0, 0, 0};
            mT = '{63, 63, 63}; mRes = 3'h0; mTerm = 3'h0; mRej = 1'b0;
        end else begin
            // Results from old selections, terminals from old results
            for (int u = 0; u < 3; u++) begin
                case (mOp[u])
                    0: nr[u] = statusFlags[mA[u]] & statusFlags[mB[u]];
                    1: nr[u] = statusFlags[mA[u]] | statusFlags[mB[u]];
                    default: nr[u] = statusFlags[mA[u]] ^ statusFlags[mB[u]];
                endcase
                if (mT[u] == 63) nt[u] = 1'b0;
                else if (mT[u] inside {[33:35]}) nt[u] = mRes[mT[u] - 33];
                else nt[u] = statusFlags[mT[u]];
            end
            mRes = nr;
            mTerm = nt;
            // Selection writes, checked for legality
            ok = !runMode && cfgUnit < 3 && cfgField < 3 && ((cfgField == 2)
                ? cfgValue < 3 : !(cfgValue inside {33, 34, 35, 44, 63}));
            if (restoreDefaults && !runMode) begin
                mA = '{0, 0, 0}; mB = '{0, 0, 1}; mOp = '{0, 0, 0};
                mRej = 1'b0;
            end else if (cfgWrite) begin
                mRej = !ok;
                if (ok && cfgField == 0) mA[cfgUnit] = cfgValue;
                if (ok && cfgField == 1) mB[cfgUnit] = cfgValue;
                if (ok && cfgField == 2) mOp[cfgUnit] = cfgValue;
            end
            if (termWrite && (runMode || termSel == 3)) mRej = 1'b1;
            else if (termWrite) mT[termSel] = termValue;
        end
    end
    // =========================================
    // Helpers
    // =========================================
    function logic [31:0] nextRand();
        rng ^= rng << 13;
        rng ^= rng >> 17;
        rng ^= rng << 5;
        return rng;
    endfunction
    task chk3(string what, logic [2:0] exp, logic [2:0] got);
        num_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask
    task chk1(string what, logic exp, logic got);
        num_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask
    // Compare at the falling edge, then drive the next inputs
    task cycle(bit rnd, bit allowRun, bit allowTerm);
        logic [31:0] r;
        @(negedge clk);
        chk3("combinedResult", mRes, combinedResult);
        chk3("routedOuts", mTerm, routed);
        chk1("cfgRejected", mRej, cfgRejected);
        r = nextRand();
        flagUpdate <= 1'b1;
        nextFlags <= {nextRand(), nextRand()};
        // Rare restores, some while running, to exercise the lock
        restoreDefaults <= rnd & allowTerm & (r[7:6] == 2'h3)
            & (r[15:14] == 2'h3);
        runMode <= allowRun & (r[3:1] == 3'h0);
        cfgWrite <= rnd & r[4] & ~r[5];
        termWrite <= rnd & allowTerm & r[5] & ~r[4];
        cfgUnit <= r[9:8];
        cfgField <= r[11:10];
        // Operator field gets small codes so all three operators occur
        cfgValue <= (r[11:10] == 2'h2) ? {4'h0, r[13:12]} : r[21:16];
        termSel <= r[23:22];
        termValue <= r[24] ? 6'h21 + {4'h0, r[26:25]} : r[31:26];
    endtask
    task print_verdict();
        $display("checks %0d mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    // =========================================
    // Main sequence
    // =========================================
    initial begin
        repeat (20) @(negedge clk);
        reset <= 1'b0;
        repeat (40) cycle(0, 0, 0);
        $display("test defaults done");
        repeat (300) cycle(1, 0, 0);
        @(negedge clk);
        restoreDefaults <= 1'b1;
        cfgWrite <= 1'b1;
        repeat (40) cycle(0, 0, 0);
        $display("test restore done");
        repeat (2000) cycle(1, 0, 1);
        $display("test stopped writes done");
        repeat (2000) cycle(1, 1, 1);
        $display("test run lock done");
        print_verdict();
    end
    // Hang guard
    initial begin
        repeat (100000) @(posedge clk);
        n_fail++;
        $display("Error timeout expected end seen none");
        print_verdict();
    end
endmodule
